// file: logic/opcode_operand_field_decode.sv
// Operand field decoder with AHB-Lite register access
//
// Contract
// - Access bit 0 uses access RAM ignoring bank_select; 1 uses bank_select.
// - Three-bit bit_number selects bit 0 to 7 of the file register.
// - Destination bit 0 writes working_accumulator; 1 writes file register.
// - file_addr is 8-bit address or 2-bit indirect_pointer designator.
// - source_file_addr is a full 12-bit read address for moves.
// - dest_file_addr is a 12-bit write address 000h to FFFh.
// - literal_value is 8, 12 or 20 bits wide per instruction.
// - table_ptr_mode: keep, post-increment, post-decrement, pre-increment.
// - branch_target is signed relative offset or absolute address.
// - Fast bit 1: call saves, return restores shadow copies.
// - Fast bit 0: call and return leave shadow registers alone.
// - table_pointer is 21 bits addressing program memory.
// - Source and destination index offsets are 7 bits each.
// - Don't-care bits are accepted with either value, no effect.
// - Byte words: opcode 15:10, dest 9, access 8, address 7:0.
// - Lone second word with four top ones executes as no-op.
// - Cycle is four periods; two when condition true or PC changes.
`timescale 1ns/10ps
module opcode_operand_field_decode
  import opdec_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int TPTR_W = 21
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire format_type instr_format,
  input wire logic cond_true,
  input wire logic [7:0] result_data,
  output logic instr_ready,
  output logic [ADDR_W-1:0] file_addr_out,
  output logic [7:0] bit_mask,
  output logic file_write,
  output logic acc_write,
  output logic [1:0] ptr_select,
  output logic ptr_load,
  output logic [19:0] literal_value,
  output logic [TPTR_W-1:0] branch_target,
  output logic pc_load,
  output logic [TPTR_W-1:0] table_addr,
  output logic table_strobe,
  output logic [ADDR_W-1:0] source_file_addr,
  output logic [ADDR_W-1:0] dest_file_addr,
  output logic move_strobe,
  output logic [6:0] source_index_offset,
  output logic [6:0] dest_index_offset,
  output logic second_word_nop,
  output logic shadow_save,
  output logic shadow_restore
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [ADDR_W-1:0] eff_addr(input logic a,
    input logic [7:0] f, input logic [3:0] bank);
    logic [3:0] b;
    b = f < ACCESS_SPLIT ? LOW_BANK : ACCESS_HIGH_BANK;
    if (a) b = bank;
    eff_addr = {b, f};
  endfunction : eff_addr

  function automatic logic [TPTR_W-1:0] sext(input logic [10:0] n,
    input logic long_form);
    if (long_form) sext = {{(TPTR_W-11){n[10]}}, n};
    else sext = {{(TPTR_W-8){n[7]}}, n[7:0]};
  endfunction : sext

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  logic [3:0] bank_select;
  logic [7:0] working_accumulator;
  logic [TPTR_W-1:0] table_pointer;
  logic [3:0] shadow_bank;
  logic [7:0] shadow_acc;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic bus_take;
  logic [31:0] next_rdata;
  state_type state;

  assign bus_take = hsel && hready && htrans == HTRANS_NONSEQ;

  always_comb begin
    next_rdata = 32'h0000_0000;
    case (haddr[7:0])
      OFS_BANK: next_rdata[3:0] = bank_select;
      OFS_ACC: next_rdata[7:0] = working_accumulator;
      OFS_TPTR: next_rdata[TPTR_W-1:0] = table_pointer;
      OFS_STATUS: next_rdata[ADDR_W:0] = {state == ST_SECOND, file_addr_out};
      OFS_SHADOW: next_rdata[11:0] = {shadow_bank, shadow_acc};
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= HRESP_OKAY;
    end else begin
      wr_pend <= bus_take && hwrite;
      wr_addr <= haddr[7:0];
      if (bus_take && !hwrite) hrdata <= next_rdata;
    end
  end

  // ----------------------------------------
  // Instruction cycle timing
  // ----------------------------------------
  logic [1:0] phase;
  logic stall;
  logic take;
  logic pc_change;
  logic [1:0] next_phase;
  logic next_stall;

  assign take = instr_valid && instr_ready;
  assign pc_change = instr_format == FMT_BRANCH_REL8 ||
    instr_format == FMT_BRANCH_REL11 || instr_format == FMT_CALL ||
    instr_format == FMT_GOTO || instr_format == FMT_RETURN;

  always_comb begin
    next_phase = phase + 2'h1;
    next_stall = stall;
    if (phase == PHASE_LAST) begin
      next_phase = PHASE_FIRST;
      if (stall) next_stall = 1'b0;
    end
    if (take && state == ST_IDLE && (pc_change || cond_true))
      next_stall = 1'b1;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= PHASE_FIRST;
      stall <= 1'b0;
      instr_ready <= 1'b0;
    end else begin
      phase <= next_phase;
      stall <= next_stall;
      instr_ready <= next_phase == PHASE_LAST && !next_stall;
    end
  end

  // ----------------------------------------
  // Double-word sequencing
  // ----------------------------------------
  logic [15:0] first_word;
  format_type first_format;
  logic lone_second;
  logic two_word;

  assign lone_second = instr_word[15:12] == SECOND_MARK;
  assign two_word = instr_format == FMT_MOVE_FF ||
    instr_format == FMT_LOAD_PTR || instr_format == FMT_CALL ||
    instr_format == FMT_GOTO || instr_format == FMT_MOVE_SF ||
    instr_format == FMT_MOVE_SS;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      first_word <= 16'h0000;
      first_format <= FMT_OTHER;
    end else if (take) begin
      case (state)
        ST_IDLE: begin
          if (two_word && !lone_second) begin
            state <= ST_SECOND;
            first_word <= instr_word;
            first_format <= instr_format;
          end
        end
        ST_SECOND: state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Operand decode
  // ----------------------------------------
  logic first_take;
  logic second_take;
  logic [7:0] fa;

  assign first_take = take && state == ST_IDLE && !lone_second;
  assign second_take = take && state == ST_SECOND;
  assign fa = instr_word[7:0];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      file_addr_out <= '0;
      bit_mask <= 8'h00;
      file_write <= 1'b0;
      acc_write <= 1'b0;
      ptr_select <= 2'h0;
      ptr_load <= 1'b0;
      literal_value <= 20'h0_0000;
      branch_target <= '0;
      pc_load <= 1'b0;
      source_file_addr <= '0;
      dest_file_addr <= '0;
      move_strobe <= 1'b0;
      source_index_offset <= 7'h00;
      dest_index_offset <= 7'h00;
      second_word_nop <= 1'b0;
    end else begin
      file_write <= 1'b0;
      acc_write <= 1'b0;
      ptr_load <= 1'b0;
      pc_load <= 1'b0;
      move_strobe <= 1'b0;
      second_word_nop <= take && state == ST_IDLE && lone_second;
      if (first_take) begin
        case (instr_format)
          FMT_BYTE: begin
            file_addr_out <= eff_addr(instr_word[8], fa, bank_select);
            file_write <= instr_word[9];
            acc_write <= !instr_word[9];
          end
          FMT_BIT: begin
            file_addr_out <= eff_addr(instr_word[8], fa, bank_select);
            bit_mask <= 8'h01 << instr_word[11:9];
          end
          FMT_LIT8: literal_value <= {12'h000, fa};
          FMT_LOAD_PTR: begin
            ptr_select <= instr_word[5:4];
            literal_value <= {8'h00, instr_word[3:0], 8'h00};
          end
          FMT_MOVE_FF: source_file_addr <= instr_word[11:0];
          FMT_MOVE_SF, FMT_MOVE_SS:
            source_index_offset <= instr_word[6:0];
          FMT_BRANCH_REL8, FMT_BRANCH_REL11: begin
            branch_target <= sext(instr_word[10:0],
              instr_format == FMT_BRANCH_REL11);
            pc_load <= 1'b1;
          end
          FMT_CALL, FMT_GOTO: literal_value <= {12'h000, fa};
          FMT_RETURN: pc_load <= 1'b1;
          default: pc_load <= 1'b0;
        endcase
      end
      if (second_take) begin
        case (first_format)
          FMT_MOVE_FF, FMT_MOVE_SF: begin
            dest_file_addr <= instr_word[11:0];
            move_strobe <= 1'b1;
          end
          FMT_MOVE_SS: begin
            dest_index_offset <= instr_word[6:0];
            move_strobe <= 1'b1;
          end
          FMT_LOAD_PTR: begin
            literal_value[7:0] <= fa;
            ptr_load <= 1'b1;
          end
          FMT_CALL, FMT_GOTO: begin
            literal_value <= {instr_word[11:0], literal_value[7:0]};
            branch_target <= {1'b0, instr_word[11:0], literal_value[7:0]};
            pc_load <= 1'b1;
          end
          default: pc_load <= 1'b0;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Bank, accumulator and shadow copies
  // ----------------------------------------
  logic fast_call;
  logic fast_ret;

  assign fast_call = first_take && instr_format == FMT_CALL &&
    instr_word[8];
  assign fast_ret = first_take && instr_format == FMT_RETURN &&
    instr_word[0];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bank_select <= BANK_RESET;
      working_accumulator <= ACC_RESET;
      shadow_bank <= BANK_RESET;
      shadow_acc <= ACC_RESET;
      shadow_save <= 1'b0;
      shadow_restore <= 1'b0;
    end else begin
      shadow_save <= fast_call;
      shadow_restore <= fast_ret;
      if (fast_call) begin
        shadow_bank <= bank_select;
        shadow_acc <= working_accumulator;
      end
      if (wr_pend && wr_addr == OFS_BANK) bank_select <= hwdata[3:0];
      if (wr_pend && wr_addr == OFS_ACC) working_accumulator <= hwdata[7:0];
      if (fast_ret) begin
        bank_select <= shadow_bank;
        working_accumulator <= shadow_acc;
      end else if (acc_write) begin
        working_accumulator <= result_data;
      end
    end
  end

  // ----------------------------------------
  // Table pointer
  // ----------------------------------------
  logic tbl_take;
  logic [1:0] tmode;

  assign tbl_take = first_take && instr_format == FMT_TABLE;
  assign tmode = instr_word[1:0];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      table_pointer <= TPTR_RESET;
      table_addr <= TPTR_RESET;
      table_strobe <= 1'b0;
    end else begin
      table_strobe <= tbl_take;
      if (wr_pend && wr_addr == OFS_TPTR)
        table_pointer <= hwdata[TPTR_W-1:0];
      if (tbl_take) begin
        case (tmode)
          TBL_KEEP: table_addr <= table_pointer;
          TBL_POST_INC: begin
            table_addr <= table_pointer;
            table_pointer <= table_pointer + 1'b1;
          end
          TBL_POST_DEC: begin
            table_addr <= table_pointer;
            table_pointer <= table_pointer - 1'b1;
          end
          TBL_PRE_INC: begin
            table_addr <= table_pointer + 1'b1;
            table_pointer <= table_pointer + 1'b1;
          end
          default: table_addr <= table_pointer;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_access_bank;
    @(posedge mclk) disable iff (!rst_n)
    first_take && instr_format == FMT_BYTE && !instr_word[8] |=>
      file_addr_out == {$past(instr_word[7:0]) < ACCESS_SPLIT ? LOW_BANK :
      ACCESS_HIGH_BANK, $past(instr_word[7:0])};
  endproperty
  a_access_bank: assert property (p_access_bank)
    else $error("access RAM bank wrong");

  property p_bank_sel;
    @(posedge mclk) disable iff (!rst_n)
    first_take && (instr_format == FMT_BYTE || instr_format == FMT_BIT) &&
      instr_word[8] |=>
      file_addr_out == {$past(bank_select), $past(instr_word[7:0])};
  endproperty
  a_bank_sel: assert property (p_bank_sel)
    else $error("bank_select not used");

  property p_bit_mask;
    @(posedge mclk) disable iff (!rst_n)
    first_take && instr_format == FMT_BIT |=>
      bit_mask == (8'h01 << $past(instr_word[11:9])) && $onehot(bit_mask);
  endproperty
  a_bit_mask: assert property (p_bit_mask)
    else $error("bit mask wrong");

  property p_dest;
    @(posedge mclk) disable iff (!rst_n)
    first_take && instr_format == FMT_BYTE |=>
      file_write == $past(instr_word[9]) && acc_write != file_write;
  endproperty
  a_dest: assert property (p_dest)
    else $error("destination select wrong");

  property p_acc_only;
    @(posedge mclk) disable iff (!rst_n)
    acc_write |-> !file_write ##1 working_accumulator == $past(result_data)
      || $past(fast_ret);
  endproperty
  a_acc_only: assert property (p_acc_only)
    else $error("accumulator path wrong");

  property p_move;
    @(posedge mclk) disable iff (!rst_n)
    second_take && first_format == FMT_MOVE_FF |=>
      move_strobe && dest_file_addr == $past(instr_word[11:0]);
  endproperty
  a_move: assert property (p_move)
    else $error("move destination wrong");

  property p_lone_nop;
    @(posedge mclk) disable iff (!rst_n)
    take && state == ST_IDLE && lone_second |=>
      second_word_nop && !pc_load && !move_strobe && state == ST_IDLE;
  endproperty
  a_lone_nop: assert property (p_lone_nop)
    else $error("lone second word not a no-op");

  property p_post_inc;
    @(posedge mclk) disable iff (!rst_n)
    tbl_take && tmode == TBL_POST_INC && !(wr_pend && wr_addr == OFS_TPTR)
      |=> table_pointer == $past(table_pointer) + 1'b1 &&
      table_addr == $past(table_pointer);
  endproperty
  a_post_inc: assert property (p_post_inc)
    else $error("post-increment wrong");

  property p_no_shadow;
    @(posedge mclk) disable iff (!rst_n)
    first_take && instr_format == FMT_CALL && !instr_word[8] |=>
      shadow_acc == $past(shadow_acc) && !shadow_save;
  endproperty
  a_no_shadow: assert property (p_no_shadow)
    else $error("shadow touched");

  property p_rel8;
    @(posedge mclk) disable iff (!rst_n)
    first_take && instr_format == FMT_BRANCH_REL8 |=>
      pc_load && branch_target[TPTR_W-1:7] == {(TPTR_W-7){branch_target[7]}};
  endproperty
  a_rel8: assert property (p_rel8)
    else $error("relative offset not sign extended");

  property p_cycle;
    @(posedge mclk) disable iff (!rst_n)
    instr_ready |=> !instr_ready [*3];
  endproperty
  a_cycle: assert property (p_cycle)
    else $error("instruction cycle too short");

  c_move: cover property (@(posedge mclk) disable iff (!rst_n)
    second_take && first_format == FMT_MOVE_FF);
  c_fast_ret: cover property (@(posedge mclk) disable iff (!rst_n)
    fast_ret);
  c_pre_inc: cover property (@(posedge mclk) disable iff (!rst_n)
    tbl_take && tmode == TBL_PRE_INC);
endmodule : opcode_operand_field_decode

// file: logic/opdec_pkg.sv
// Constants and types for the operand field decoder
package opdec_pkg;
  // Register byte offsets on the bus
  localparam logic [7:0] OFS_BANK = 8'h00;
  localparam logic [7:0] OFS_ACC = 8'h04;
  localparam logic [7:0] OFS_TPTR = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_SHADOW = 8'h10;
  // Reset values
  localparam logic [3:0] BANK_RESET = 4'h0;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [20:0] TPTR_RESET = 21'h00_0000;
  // Access RAM split and its upper bank
  localparam logic [7:0] ACCESS_SPLIT = 8'h80;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
  localparam logic [3:0] LOW_BANK = 4'h0;
  // Second word marker in the four top bits
  localparam logic [3:0] SECOND_MARK = 4'hF;
  // Table pointer modes
  localparam logic [1:0] TBL_KEEP = 2'h0;
  localparam logic [1:0] TBL_POST_INC = 2'h1;
  localparam logic [1:0] TBL_POST_DEC = 2'h2;
  localparam logic [1:0] TBL_PRE_INC = 2'h3;
  // Oscillator periods per instruction cycle
  localparam logic [1:0] PHASE_LAST = 2'h3;
  localparam logic [1:0] PHASE_FIRST = 2'h0;
  // Bus encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;
  typedef enum logic [3:0] {
    FMT_BYTE, FMT_BIT, FMT_MOVE_FF, FMT_LOAD_PTR, FMT_LIT8, FMT_TABLE,
    FMT_BRANCH_REL8, FMT_BRANCH_REL11, FMT_CALL, FMT_GOTO, FMT_RETURN,
    FMT_MOVE_SF, FMT_MOVE_SS, FMT_OTHER
  } format_type;
  typedef enum logic {ST_IDLE, ST_SECOND} state_type;
endpackage : opdec_pkg

// file: dv/program_memory_model.sv
// Program memory model offering instruction words to the decoder
`timescale 1ns/10ps
module program_memory_model
  import opdec_pkg::*;
(
  input wire logic mclk,
  input wire logic instr_ready,
  output logic instr_valid,
  output logic [15:0] instr_word,
  output format_type instr_format,
  output logic cond_true
);
  logic timed_out;
  initial begin
    instr_valid = 1'b0;
    instr_word = 16'h0000;
    instr_format = FMT_OTHER;
    cond_true = 1'b0;
    timed_out = 1'b0;
  end
  // ----------------------------------------
  // Word offer: hold until taken, then scramble
  // ----------------------------------------
  task automatic offer(input logic [15:0] w, input format_type f,
                       input logic c);
    int n;
    @(posedge mclk);
    instr_valid <= 1'b1;
    instr_word <= w;
    instr_format <= f;
    cond_true <= c;
    for (n = 0; n < 40; n++) begin
      @(posedge mclk);
      if (instr_ready === 1'b1) break;
    end
    if (n == 40) timed_out = 1'b1;
    instr_valid <= 1'b0;
    instr_word <= ~w;
    instr_format <= FMT_OTHER;
    cond_true <= ~c;
  endtask : offer
endmodule : program_memory_model

// file: dv/opcode_operand_field_decode_bench.sv
// Self-checking bench for the operand field decoder
`timescale 1ns/10ps
module opcode_operand_field_decode_bench;
  import opdec_pkg::*;
  localparam logic [31:0] ONE = 32'h0000_0001;
  localparam logic [31:0] ZERO = 32'h0000_0000;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [7:0] result_data = 8'hC4;
  logic [31:0] hrdata;
  logic hreadyout, hresp, instr_valid, instr_ready, cond_true;
  logic [15:0] instr_word;
  format_type instr_format;
  logic [11:0] file_addr_out, source_file_addr, dest_file_addr;
  logic [7:0] bit_mask;
  logic [1:0] ptr_select;
  logic [19:0] literal_value;
  logic [20:0] branch_target, table_addr;
  logic [6:0] source_index_offset, dest_index_offset;
  logic file_write, acc_write, ptr_load, pc_load, table_strobe;
  logic move_strobe, second_word_nop, shadow_save, shadow_restore;
  logic [7:0] pulses;
  int cnt [8];
  int num_errors = 0;
  int total_checks = 0;

  always #20 mclk = ~mclk;

  opcode_operand_field_decode opcode_operand_field_decode_inst (
    .mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .instr_valid(instr_valid), .instr_word(instr_word),
    .instr_format(instr_format), .cond_true(cond_true),
    .result_data(result_data), .instr_ready(instr_ready),
    .file_addr_out(file_addr_out), .bit_mask(bit_mask),
    .file_write(file_write), .acc_write(acc_write),
    .ptr_select(ptr_select), .ptr_load(ptr_load),
    .literal_value(literal_value), .branch_target(branch_target),
    .pc_load(pc_load), .table_addr(table_addr),
    .table_strobe(table_strobe), .source_file_addr(source_file_addr),
    .dest_file_addr(dest_file_addr), .move_strobe(move_strobe),
    .source_index_offset(source_index_offset),
    .dest_index_offset(dest_index_offset),
    .second_word_nop(second_word_nop), .shadow_save(shadow_save),
    .shadow_restore(shadow_restore)
  );

  program_memory_model program_memory_model_inst (
    .mclk(mclk), .instr_ready(instr_ready), .instr_valid(instr_valid),
    .instr_word(instr_word), .instr_format(instr_format),
    .cond_true(cond_true)
  );

  // ----------------------------------------
  // Pulse counters
  // ----------------------------------------
  assign pulses = {shadow_restore, shadow_save, second_word_nop, ptr_load,
                   move_strobe, table_strobe, acc_write, file_write};
  always @(posedge mclk) begin
    for (int i = 0; i < 8; i++) begin
      if (pulses[i] === 1'b1) cnt[i]++;
    end
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic print_verdict();
    if (num_errors == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : print_verdict

  task automatic hang();
    num_errors++;
    $display("MISMATCH %0t wait limit reached", $time);
    print_verdict();
  endtask : hang

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic wait_ready();
    int n;
    for (n = 0; n < 16; n++) begin
      @(posedge mclk);
      if (hreadyout === 1'b1) break;
    end
    if (n == 16) hang();
  endtask : wait_ready

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, ZERO, r);
    check(r, e);
  endtask : rd_chk

  task automatic run(input logic [15:0] w, input format_type f,
                     input logic c);
    program_memory_model_inst.offer(w, f, c);
    if (program_memory_model_inst.timed_out) hang();
  endtask : run

  task automatic settle();
    repeat (3) @(posedge mclk);
    #1;
  endtask : settle

  task automatic clear();
    for (int i = 0; i < 8; i++) cnt[i] = 0;
  endtask : clear

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    rd_chk(OFS_BANK, ZERO);
    check({31'h0, hresp}, ZERO);
    rd_chk(OFS_ACC, ZERO);
    rd_chk(OFS_TPTR, ZERO);
    wr(8'h14, 32'hFFFF_FFFF);
    rd_chk(8'h14, ZERO);
    wr(OFS_TPTR, 32'hFFFF_FFFF);
    rd_chk(OFS_TPTR, 32'h001F_FFFF);
    wr(OFS_BANK, 32'hFFFF_FFFF);
    rd_chk(OFS_BANK, 32'h0000_000F);
  endtask : t_regs

  task automatic byte_case(input logic d, input logic a,
                           input logic [7:0] f, input logic [11:0] ea);
    wr(OFS_BANK, 32'h0000_0005);
    wr(OFS_ACC, 32'h0000_0033);
    clear();
    run({6'h09, d, a, f}, FMT_BYTE, 1'b0);
    settle();
    check(32'(file_addr_out), 32'(ea));
    check(32'(cnt[0]), {31'h0, d});
    check(32'(cnt[1]), {31'h0, ~d});
    rd_chk(OFS_ACC, d ? 32'h0000_0033 : 32'h0000_00C4);
  endtask : byte_case

  task automatic t_bit();
    for (int b = 0; b < 8; b++) begin
      run({4'h8, 3'(b), 1'b0, 8'h10}, FMT_BIT, 1'b0);
      settle();
      check(32'(bit_mask), ONE << b);
    end
  endtask : t_bit

  task automatic t_move();
    clear();
    run({4'hC, 12'hABC}, FMT_MOVE_FF, 1'b0);
    run({4'hF, 12'h123}, FMT_BYTE, 1'b0);
    settle();
    check(32'(source_file_addr), 32'h0000_0ABC);
    check(32'(dest_file_addr), 32'h0000_0123);
    check(32'(cnt[3]), ONE);
    check(32'(cnt[0] + cnt[1]), ZERO);
    clear();
    run(16'hF123, FMT_OTHER, 1'b0);
    settle();
    check(32'(cnt[5]), ONE);
    check(32'(cnt[3]), ZERO);
    run({4'hE, 5'h00, 7'h25}, FMT_MOVE_SS, 1'b0);
    run({4'hF, 5'h00, 7'h5A}, FMT_OTHER, 1'b0);
    settle();
    check(32'(source_index_offset), 32'h0000_0025);
    check(32'(dest_index_offset), 32'h0000_005A);
  endtask : t_move

  task automatic t_branch();
    run(16'hE0FE, FMT_BRANCH_REL8, 1'b0);
    #1;
    check({31'h0, pc_load}, ONE);
    settle();
    check(32'(branch_target), 32'h001F_FFFE);
    run(16'hD500, FMT_BRANCH_REL11, 1'b0);
    settle();
    check(32'(branch_target), 32'h001F_FD00);
  endtask : t_branch

  task automatic t_lit();
    run(16'h0EA5, FMT_LIT8, 1'b0);
    settle();
    check(32'(literal_value), 32'h0000_00A5);
    clear();
    run({8'hEE, 2'b00, 2'h2, 4'h3}, FMT_LOAD_PTR, 1'b0);
    run({4'hF, 4'h0, 8'hC7}, FMT_OTHER, 1'b0);
    settle();
    check(32'(ptr_select), 32'h0000_0002);
    check(32'(literal_value), 32'h0000_03C7);
    check(32'(cnt[4]), ONE);
  endtask : t_lit

  task automatic tbl(input logic [1:0] m, input logic [20:0] p,
                     input logic [20:0] ea, input logic [20:0] ep);
    wr(OFS_TPTR, 32'(p));
    clear();
    run({14'h0002, m}, FMT_TABLE, 1'b0);
    settle();
    check(32'(table_addr), 32'(ea));
    check(32'(cnt[2]), ONE);
    rd_chk(OFS_TPTR, 32'(ep));
  endtask : tbl

  task automatic t_fast();
    wr(OFS_BANK, 32'h0000_0003);
    wr(OFS_ACC, 32'h0000_005A);
    clear();
    run({7'h76, 1'b1, 8'h20}, FMT_CALL, 1'b0);
    run(16'hF000, FMT_OTHER, 1'b0);
    wr(OFS_BANK, 32'h0000_0007);
    wr(OFS_ACC, 32'h0000_0011);
    run(16'h0013, FMT_RETURN, 1'b0);
    settle();
    check(32'(cnt[6] + cnt[7]), 32'h0000_0002);
    check(32'(branch_target), 32'h0000_0020);
    rd_chk(OFS_BANK, 32'h0000_0003);
    rd_chk(OFS_ACC, 32'h0000_005A);
    clear();
    run({7'h76, 1'b0, 8'h20}, FMT_CALL, 1'b0);
    run(16'hF000, FMT_OTHER, 1'b0);
    wr(OFS_BANK, 32'h0000_0009);
    run(16'h0012, FMT_RETURN, 1'b0);
    settle();
    check(32'(cnt[6] + cnt[7]), ZERO);
    rd_chk(OFS_BANK, 32'h0000_0009);
    rd_chk(OFS_SHADOW, 32'h0000_035A);
  endtask : t_fast

  task automatic gap(input logic c, input int e);
    int n;
    run(16'h2610, FMT_BYTE, c);
    for (n = 1; n <= 12; n++) begin
      @(posedge mclk);
      if (instr_ready === 1'b1) break;
    end
    check(32'(n), 32'(e));
  endtask : gap

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    t_regs();
    byte_case(1'b1, 1'b0, 8'h7F, 12'h07F);
    byte_case(1'b0, 1'b0, 8'h80, 12'hF80);
    byte_case(1'b1, 1'b1, 8'h12, 12'h512);
    byte_case(1'b0, 1'b1, 8'hFF, 12'h5FF);
    t_bit();
    t_move();
    t_lit();
    t_branch();
    tbl(TBL_KEEP, 21'h00_0010, 21'h00_0010, 21'h00_0010);
    tbl(TBL_POST_INC, 21'h00_0010, 21'h00_0010, 21'h00_0011);
    tbl(TBL_POST_DEC, 21'h00_0010, 21'h00_0010, 21'h00_000F);
    tbl(TBL_PRE_INC, 21'h00_0010, 21'h00_0011, 21'h00_0011);
    tbl(TBL_POST_INC, 21'h1F_FFFF, 21'h1F_FFFF, 21'h00_0000);
    t_fast();
    gap(1'b0, 4);
    gap(1'b1, 8);
    print_verdict();
  end
endmodule : opcode_operand_field_decode_bench
